// ==== hdl/pwmto_regs.svh ====
// Register offsets, field positions, reset values and fixed counts
// for the PWM and tone output block; included by the package.
`ifndef PWMTO_REGS_SVH
`define PWMTO_REGS_SVH

`define PWMTO_ADDR_W          3
`define PWMTO_DATA_W          8

`define PWMTO_OFS_CTRL        3'h0
`define PWMTO_OFS_MAIN_DUTY   3'h1
`define PWMTO_OFS_MAIN_PERIOD 3'h2
`define PWMTO_OFS_SIMPLE_DUTY 3'h3
`define PWMTO_OFS_TONE_CFG    3'h4
`define PWMTO_OFS_TONE_CTRL   3'h5
`define PWMTO_OFS_STATUS      3'h6
`define PWMTO_OFS_MAIN_COUNT  3'h7

// Control register fields
`define PWMTO_CTRL_CLEAR_HOLD 0
`define PWMTO_CTRL_PIN_EN     1
`define PWMTO_CTRL_INVERT     2
`define PWMTO_CTRL_IRQ_EN     3
`define PWMTO_CTRL_PSC_LO     4
`define PWMTO_CTRL_PSC_HI     5
`define PWMTO_CTRL_SIMPLE_EN  6
`define PWMTO_CTRL_RESET      8'h01

// Tone configuration fields, then tone control fields (enable, pin enable)
`define PWMTO_TONE_PERIOD_HI  5
`define PWMTO_TONE_PSC_LO     6
`define PWMTO_TONE_PSC_HI     7
`define PWMTO_TONE_EN         0
`define PWMTO_TONE_PIN_EN     1

// Status fields
`define PWMTO_STAT_PENDING    0
`define PWMTO_STAT_MAIN_LEVEL 1

// Main divider masks for divide by 1, 2, 4, 8
`define PWMTO_MAIN_MASK_1     3'h0
`define PWMTO_MAIN_MASK_2     3'h1
`define PWMTO_MAIN_MASK_4     3'h3
`define PWMTO_MAIN_MASK_8     3'h7

// Tone divider terminal counts (ratio minus one)
`define PWMTO_TONE_DIV_0      5'h03
`define PWMTO_TONE_DIV_1      5'h07
`define PWMTO_TONE_DIV_2      5'h0F
`define PWMTO_TONE_DIV_3      5'h1F

`endif

// ==== hdl/pwmto_pkg.sv ====
// Types shared by the PWM and tone output block.
// Assumes pwmto_regs.svh is on the include path.
`include "pwmto_regs.svh"

package pwmto_pkg;

  typedef struct packed {
    logic value;
    logic oe;
  } pwmto_pin_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] main_duty_value;
    logic [7:0] main_period_value;
    logic [7:0] simple_duty_value;
    logic [7:0] tone_cfg;
    logic [1:0] tone_ctrl;
    logic       pending;
    logic [7:0] rdata;
    logic [2:0] main_div;
    logic [7:0] main_counter;
    logic [7:0] main_duty_shadow;
    logic       main_wave;
    logic       held;
    logic       main_event;
    logic [7:0] simple_counter;
    logic       simple_wave;
    logic [4:0] tone_div;
    logic [5:0] tone_counter;
    logic       tone_wave;
    pwmto_pin_t main_pin;
    pwmto_pin_t simple_pin;
    pwmto_pin_t tone_pin;
  } pwmto_state_t;

endpackage : pwmto_pkg

// ==== hdl/pwmto_top.sv ====
// Main PWM, simple fixed-period PWM and square-wave tone generator.
// Assumes a single clock, a same-domain register master and push-pull pins.
// Notes on behaviour
// (RQ1) Main counter 8-bit, divider 1/2/4/8
// (RQ2) Duty writes spare the running period
// (RQ3) Period end copies duty into shadow
// (RQ4) Enabled, not inverted: true waveform out
// (RQ5) Enabled, inverted: complement waveform out
// (RQ6) Period end raises event when enabled
// (RQ7) Hold keeps counter zero, loads shadow
// (RQ8) Hold control resets to one
// (RQ9) Hold forces main waveform low
// (RQ10) Release drives waveform high, new cycle
// (RQ11) Waveform low when counter reaches shadow
// (RQ12) Period match ends period, waveform high
// (RQ13) Counter restarts at zero after match
// (RQ14) Simple counter runs 0 to 255
// (RQ15) Simple high time equals duty clocks
// (RQ16) Simple high while counter below duty
// (RQ17) Simple pin driven only when enabled
// (RQ18) Tone: prescaler, 6-bit counter, 50% duty
// (RQ19) Tone needs enable and pin enable
// (RQ20) Tone frequency from divider and period
// (RQ21) Tone select 2'b11 divides by 32
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "pwmto_regs.svh"

module pwmto_top
  import pwmto_pkg::*;
(
  input  wire logic                     clk,               // 10 MHz clock
  input  wire logic                     rst,               // Async reset, high
  input  wire logic                     ce,                // Clock enable
  input  wire logic [`PWMTO_ADDR_W-1:0] addr,              // Register address
  input  wire logic [`PWMTO_DATA_W-1:0] wdata,             // Write data
  input  wire logic                     wr,                // Write strobe
  input  wire logic                     rd,                // Read strobe
  output      logic [`PWMTO_DATA_W-1:0] rdata,             // Read data, next cycle
  output      logic                     main_period_event, // Period done pulse
  output      logic                     main_output_pin,   // Main PWM pin value
  output      logic                     main_output_oe,    // Main PWM pin enable
  output      logic                     simple_output_pin, // Simple PWM pin value
  output      logic                     simple_output_oe,  // Simple PWM pin enable
  output      logic                     tone_output_pin,   // Tone pin value
  output      logic                     tone_output_oe     // Tone pin enable
);

  pwmto_state_t st;
  pwmto_state_t next_st;

  logic       clear_hold;
  logic [2:0] main_mask;
  logic       main_tick;
  logic [4:0] tone_term;
  logic [7:0] next_count;

  assign clear_hold = st.ctrl[`PWMTO_CTRL_CLEAR_HOLD];

  // RQ1 main clock divider select
  always_comb begin
    case (st.ctrl[`PWMTO_CTRL_PSC_HI:`PWMTO_CTRL_PSC_LO])
      2'b00:   main_mask = `PWMTO_MAIN_MASK_1;
      2'b01:   main_mask = `PWMTO_MAIN_MASK_2;
      2'b10:   main_mask = `PWMTO_MAIN_MASK_4;
      default: main_mask = `PWMTO_MAIN_MASK_8;
    endcase
  end

  // RQ21 tone prescale ratios
  always_comb begin
    case (st.tone_cfg[`PWMTO_TONE_PSC_HI:`PWMTO_TONE_PSC_LO])
      2'b00:   tone_term = `PWMTO_TONE_DIV_0;
      2'b01:   tone_term = `PWMTO_TONE_DIV_1;
      2'b10:   tone_term = `PWMTO_TONE_DIV_2;
      default: tone_term = `PWMTO_TONE_DIV_3;
    endcase
  end

  assign main_tick  = ((st.main_div & main_mask) == main_mask);
  assign next_count = st.main_counter + 8'h01;

  always_comb begin
    next_st            = st;
    next_st.main_event = 1'b0;

    // Register writes
    if (wr) begin
      case (addr)
        `PWMTO_OFS_CTRL:        next_st.ctrl = wdata;
        // RQ2 only the written value changes here
        `PWMTO_OFS_MAIN_DUTY:   next_st.main_duty_value = wdata;
        `PWMTO_OFS_MAIN_PERIOD: next_st.main_period_value = wdata;
        `PWMTO_OFS_SIMPLE_DUTY: next_st.simple_duty_value = wdata;
        `PWMTO_OFS_TONE_CFG:    next_st.tone_cfg = wdata;
        `PWMTO_OFS_TONE_CTRL:   next_st.tone_ctrl = wdata[1:0];
        `PWMTO_OFS_STATUS: begin
          if (!wdata[`PWMTO_STAT_PENDING]) begin
            next_st.pending = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Register reads, data in the following cycle
    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `PWMTO_OFS_CTRL:        next_st.rdata = st.ctrl;
        `PWMTO_OFS_MAIN_DUTY:   next_st.rdata = st.main_duty_value;
        `PWMTO_OFS_MAIN_PERIOD: next_st.rdata = st.main_period_value;
        `PWMTO_OFS_SIMPLE_DUTY: next_st.rdata = st.simple_duty_value;
        `PWMTO_OFS_TONE_CFG:    next_st.rdata = st.tone_cfg;
        `PWMTO_OFS_TONE_CTRL:   next_st.rdata = {6'h00, st.tone_ctrl};
        `PWMTO_OFS_STATUS:      next_st.rdata = {6'h00, st.main_wave, st.pending};
        `PWMTO_OFS_MAIN_COUNT:  next_st.rdata = st.main_counter;
        default:                next_st.rdata = 8'h00;
      endcase
    end

    // Main PWM
    next_st.held = clear_hold;
    if (clear_hold) begin
      // RQ7 counter held, shadow loaded
      next_st.main_counter     = 8'h00;
      next_st.main_duty_shadow = st.main_duty_value;
      next_st.main_div         = 3'h0;
      // RQ9 output forced low
      next_st.main_wave        = 1'b0;
    end else if (st.held) begin
      // RQ10 release starts a new cycle high
      next_st.main_wave = 1'b1;
      next_st.main_div  = 3'h1;
    end else begin
      // RQ1 divided clock advances the counter
      next_st.main_div = st.main_div + 3'h1;
      if (main_tick) begin
        if (st.main_counter == st.main_period_value) begin
          // RQ13 restart from zero
          next_st.main_counter     = 8'h00;
          // RQ3 shadow reload at period end
          next_st.main_duty_shadow = st.main_duty_value;
          // RQ12 output high for next cycle
          next_st.main_wave        = 1'b1;
          // RQ6 period event when enabled
          if (st.ctrl[`PWMTO_CTRL_IRQ_EN]) begin
            next_st.main_event = 1'b1;
          end
        end else begin
          next_st.main_counter = next_count;
          // RQ11 low once counter reaches shadow
          if (next_count >= st.main_duty_shadow) begin
            next_st.main_wave = 1'b0;
          end
        end
      end
    end

    // Pending flag: set wins over a same-cycle clear
    if (next_st.main_event) begin
      next_st.pending = 1'b1;
    end

    // RQ14 simple counter wraps after 255
    next_st.simple_counter = st.simple_counter + 8'h01;
    // RQ16 high below duty
    // RQ15 duty clocks out of 256
    next_st.simple_wave    = (next_st.simple_counter < st.simple_duty_value);

    // RQ18 tone prescaler and 6-bit counter
    if (!st.tone_ctrl[`PWMTO_TONE_EN]) begin
      next_st.tone_div     = 5'h00;
      next_st.tone_counter = 6'h00;
      next_st.tone_wave    = 1'b0;
    end else if (st.tone_div >= tone_term) begin
      next_st.tone_div = 5'h00;
      // RQ20 toggle every divider times period+1 clocks
      if (st.tone_counter >= st.tone_cfg[`PWMTO_TONE_PERIOD_HI:0]) begin
        next_st.tone_counter = 6'h00;
        next_st.tone_wave    = ~st.tone_wave;
      end else begin
        next_st.tone_counter = st.tone_counter + 6'h01;
      end
    end else begin
      next_st.tone_div = st.tone_div + 5'h01;
    end

    // RQ4 true waveform when not inverted
    // RQ5 complement when inverted
    next_st.main_pin.oe    = next_st.ctrl[`PWMTO_CTRL_PIN_EN];
    next_st.main_pin.value = next_st.ctrl[`PWMTO_CTRL_PIN_EN] &
                             (next_st.main_wave ^ next_st.ctrl[`PWMTO_CTRL_INVERT]);
    // RQ17 simple pin gated by enable
    next_st.simple_pin.oe    = next_st.ctrl[`PWMTO_CTRL_SIMPLE_EN];
    next_st.simple_pin.value = next_st.ctrl[`PWMTO_CTRL_SIMPLE_EN] & next_st.simple_wave;
    // RQ19 tone needs both controls
    next_st.tone_pin.oe    = next_st.tone_ctrl[`PWMTO_TONE_PIN_EN];
    next_st.tone_pin.value = next_st.tone_ctrl[`PWMTO_TONE_PIN_EN] &
                             next_st.tone_ctrl[`PWMTO_TONE_EN] & next_st.tone_wave;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st      <= '0;
      // RQ8 hold control out of reset set
      st.ctrl <= `PWMTO_CTRL_RESET;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata             = st.rdata;
  assign main_period_event = st.main_event;
  assign main_output_pin   = st.main_pin.value;
  assign main_output_oe    = st.main_pin.oe;
  assign simple_output_pin = st.simple_pin.value;
  assign simple_output_oe  = st.simple_pin.oe;
  assign tone_output_pin   = st.tone_pin.value;
  assign tone_output_oe    = st.tone_pin.oe;

endmodule : pwmto_top

// ==== verif/pwmto_monitor.sv ====
// Checker for the PWM and tone block, bound to its top ports.
// Assumes ctrl and tone writes land at the edge that takes them.
`timescale 1ns/1ps
`include "pwmto_regs.svh"
module pwmto_monitor
  import pwmto_pkg::*;
(
  input wire logic       clk,               // Clock
  input wire logic       rst,               // Reset
  input wire logic       ce,                // Clock enable
  input wire logic [2:0] addr,              // Address
  input wire logic [7:0] wdata,             // Write data
  input wire logic       wr,                // Write strobe
  input wire logic       main_period_event, // Period pulse
  input wire logic       main_output_pin,   // Main pin
  input wire logic       main_output_oe,    // Main enable
  input wire logic       simple_output_oe,  // Simple enable
  input wire logic       tone_output_pin,   // Tone pin
  input wire logic       tone_output_oe     // Tone enable
);
  logic [7:0] cm;
  logic [1:0] tm;
  // Copies of control written by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cm <= 8'h01;
      tm <= 2'h0;
    end else if (ce && wr) begin
      if (addr == `PWMTO_OFS_CTRL) cm <= wdata;
      if (addr == `PWMTO_OFS_TONE_CTRL) tm <= wdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_oe; main_output_oe == cm[1]; endproperty
  a_oe: assert property (p_oe) else $error("main enable wrong");
  property p_lo; cm[0] && $past(cm[0]) && !cm[2] |-> !main_output_pin; endproperty
  a_lo: assert property (p_lo) else $error("held output not low");
  property p_inv; cm[0] && $past(cm[0]) && cm[2] && cm[1] |-> main_output_pin; endproperty
  a_inv: assert property (p_inv) else $error("inverted held not high");
  property p_go; $fell(cm[0]) && cm[1] && !cm[2] |-> ##[0:2] main_output_pin; endproperty
  a_go: assert property (p_go) else $error("release not high");
  property p_irq; !cm[3] && !$past(cm[3]) |-> !main_period_event; endproperty
  a_irq: assert property (p_irq) else $error("event while disabled");
  property p_held; cm[0] && $past(cm[0]) |-> !main_period_event; endproperty
  a_held: assert property (p_held) else $error("event while held");
  property p_ev; main_period_event && main_output_oe |-> main_output_pin != cm[2]; endproperty
  a_ev: assert property (p_ev) else $error("period start not high");
  property p_soe; simple_output_oe == cm[6]; endproperty
  a_soe: assert property (p_soe) else $error("simple enable wrong");
  property p_tone; tone_output_oe == tm[1] && (tm == 2'b11 || !tone_output_pin); endproperty
  a_tone: assert property (p_tone) else $error("tone gating wrong");
  c_ev: cover property (main_period_event);
  c_tone: cover property (tone_output_pin);
  c_go: cover property ($fell(cm[0]));
endmodule : pwmto_monitor

bind pwmto_top pwmto_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .main_period_event(main_period_event),
  .main_output_pin(main_output_pin), .main_output_oe(main_output_oe),
  .simple_output_oe(simple_output_oe), .tone_output_pin(tone_output_pin),
  .tone_output_oe(tone_output_oe));

// ==== verif/pwmto_load.sv ====
// Pin load: pull-down on each pin, measures each high pulse.
// Assumes pins are push-pull, undriven when enable is low.
`timescale 1ns/1ps
module pwmto_load (
  input  wire logic        clk,       // Clock
  input  wire logic [2:0]  pin,       // Pin values
  input  wire logic [2:0]  oe,        // Pin enables
  output      logic [2:0]  fire,      // Pulse ended
  output      logic [11:0] width [3]  // Last pulse length
);
  logic [2:0]  lvl;
  logic [11:0] run [3] = '{3{12'd0}};
  assign lvl = pin & oe;
  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      fire[i]  <= (run[i] != 12'd0) && !lvl[i];
      width[i] <= run[i];
      run[i]   <= lvl[i] ? run[i] + 12'd1 : 12'd0;
    end
  end
endmodule : pwmto_load

// ==== verif/pwmto_tb_top.sv ====
// Bench for the PWM and tone block: register port driver and
// a watcher that compares read data and pin pulse widths.
`timescale 1ns/1ps
`include "pwmto_regs.svh"
module pwmto_tb_top;
  import pwmto_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  rdata;
  logic        ev;
  logic [2:0]  pin, oe, fire;
  logic [11:0] width [3];
  logic [7:0]  rq[$];
  int          wq[$];
  int          bad_count = 0;
  int          num_checks = 0;
  int          lane = 0;
  int          skip = 0;
  int          ev_gap = 0;
  int          ev_last = 0;
  int          p, d, q, w, t;
  always #50 clk = ~clk;
  pwmto_top uut (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .main_period_event(ev), .main_output_pin(pin[0]),
    .main_output_oe(oe[0]), .simple_output_pin(pin[1]), .simple_output_oe(oe[1]),
    .tone_output_pin(pin[2]), .tone_output_oe(oe[2]));
  pwmto_load load (.clk(clk), .pin(pin), .oe(oe), .fire(fire),
    .width(width));
  task close_out();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Results in order of their notes
  always @(posedge clk) begin
    rd_d <= rd;
    if (ev === 1'b1) begin
      ev_last <= ev_gap + 1;
      ev_gap  <= 0;
    end else begin
      ev_gap <= ev_gap + 1;
    end
    if (rd_d) chk({4'h0, rdata}, {4'h0, rq.pop_front()});
    if (fire[lane] === 1'b1) begin
      if (skip > 0) skip--;
      else if (wq.size() > 0) chk(width[lane], 12'(wq.pop_front()));
    end
  end
  task put(input logic [2:0] a, input logic [7:0] v, input logic r);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= !r;
    rd    <= r;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : put
  task get(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    put(a, 8'h00, 1'b1);
  endtask : get
  // Pulses to skip after a change, then two widths to expect
  task meas(input int ln, input int s, input int w0, input int w1);
    int n;
    n = 0;
    lane = ln;
    skip = s;
    wq = {w0, w1};
    while (wq.size() > 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      bad_count++;
      $display("[ERR] %0t no pulse on lane %0d", $time, ln);
      close_out();
    end
  endtask : meas
  initial begin
    void'($urandom(32'h0675_9575));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    get(`PWMTO_OFS_CTRL, `PWMTO_CTRL_RESET);
    get(`PWMTO_OFS_MAIN_COUNT, 8'h00);
    for (int k = 0; k < 4; k++) begin
      p = 2 + $urandom % 14;
      d = 1 + $urandom % p;
      put(`PWMTO_OFS_CTRL, {5'h00, 1'(k == 3), 2'b11}, 1'b0);
      get(`PWMTO_OFS_STATUS, {7'h00, 1'(k > 0)});
      put(`PWMTO_OFS_STATUS, 8'h00, 1'b0);
      get(`PWMTO_OFS_STATUS, 8'h00);
      put(`PWMTO_OFS_MAIN_PERIOD, 8'(p), 1'b0);
      put(`PWMTO_OFS_MAIN_DUTY, 8'(d), 1'b0);
      put(`PWMTO_OFS_CTRL, {2'b01, 2'(k), 1'b1, k == 3, 2'b10}, 1'b0);
      w = (k == 3) ? (p + 1 - d) << k : d << k;
      meas(0, 2, w, w);
      chk(12'(ev_last), 12'((p + 1) << k));
      if (k == 2) begin
        // Duty write just after a period start
        t = 0;
        while (ev !== 1'b1 && t < 5000) begin
          @(posedge clk);
          t++;
        end
        if (t >= 5000) begin
          bad_count++;
          $display("[ERR] %0t no period event", $time);
          close_out();
        end
        q = 1 + $urandom % p;
        put(`PWMTO_OFS_MAIN_DUTY, 8'(q), 1'b0);
        meas(0, 0, d << 2, q << 2);
      end
    end
    d = 1 + $urandom % 255;
    put(`PWMTO_OFS_SIMPLE_DUTY, 8'(d), 1'b0);
    meas(1, 2, d, d);
    for (int k = 0; k < 4; k++) begin
      p = $urandom % 8;
      put(`PWMTO_OFS_TONE_CFG, {2'(k), 6'(p)}, 1'b0);
      put(`PWMTO_OFS_TONE_CTRL, 8'h01, 1'b0);
      put(`PWMTO_OFS_TONE_CTRL, 8'h03, 1'b0);
      w = (4 << k) * (p + 1);
      meas(2, 2, w, w);
    end
    close_out();
  end
endmodule : pwmto_tb_top
